// File: core/dgp_pin_mux.sv
`timescale 1ns/1ns
`default_nettype none
module dgp_pin_mux import dgp_pkg::*; #(
  parameter int W = 4
) (
  // Port state
  input wire logic [W-1:0] latch,
  input wire logic [W-1:0] dir,
  // Alternate function
  input wire logic [W-1:0] alt_en,
  input wire logic [W-1:0] alt_val,
  // Pad side
  output logic [W-1:0] pin_o,
  output logic [W-1:0] pin_oe
);

  if (W < 1) begin : g_bad_w
    $error("dgp_pin_mux width must be at least one");
  end

  for (genvar i = 0; i < W; i++) begin : g_pin
    // Alternate function overrides the direction bit
    assign pin_o[i] = alt_en[i] ? alt_val[i] : latch[i];
    assign pin_oe[i] = alt_en[i] | ~dir[i];
  end

endmodule
`default_nettype wire

// File: core/dgp_pkg.sv
// Notes on behaviour
// - Bus-control port: four pins, latch and direction each
// - Direction one means input, zero drives latch
// - Read returns pins; write loads latch only
// - Bus mode pins carry latch, read, write strobes
// - Read and write strobes are active low
// - Bus modes take three pins; fourth stays GPIO
// - Other modes keep low three pins as GPIO
// - Analog port: eight pins, upper four analog
// - Analog direction resets to all ones
// - Power-on clears data; warm reset keeps low nibble
package dgp_pkg;

  // APB geometry; byte address is four times the register index
  localparam int APB_AW = 8;
  localparam int APB_DW = 32;
  localparam int IDX_W = APB_AW - 2;

  // Register indices
  localparam logic [IDX_W-1:0] IDX_ANA_DIR = 6'h10;
  localparam logic [IDX_W-1:0] IDX_ANA_DATA = 6'h11;
  localparam logic [IDX_W-1:0] IDX_BUS_DATA = 6'h12;
  localparam logic [IDX_W-1:0] IDX_BUS_DIR = 6'h13;
  localparam logic [IDX_W-1:0] IDX_STATUS = 6'h14;
  localparam logic [IDX_W-1:0] IDX_CONV_CTRL = 6'h15;

  // Reset values
  localparam logic [7:0] ANA_DIR_RST = 8'hFF;
  localparam logic [3:0] ANA_DATA_HI_RST = 4'h0;
  localparam logic [3:0] ANA_DATA_LO_RST = 4'h0;
  localparam logic [7:0] CONV_CTRL_RST = 8'h00;
  localparam logic [3:0] BUS_DIR_RST = 4'hF;
  localparam logic [3:0] BUS_DATA_RST = 4'h0;

  // Converter control fields
  localparam int CONV_CFG_LSB = 0;
  localparam int CONV_CFG_W = 4;
  localparam logic [7:0] CONV_CTRL_WMASK = 8'hEF;
  localparam logic [3:0] CFG_DIGITAL_FROM = 4'h8;

  // Bus-control pin roles
  localparam int BUS_ALE_BIT = 0;
  localparam int BUS_OE_BIT = 1;
  localparam int BUS_WR_BIT = 2;
  localparam int BUS_CAP_BIT = 3;
  localparam logic [3:0] BUS_TAKE_MASK = 4'h7;

  // Status fields
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_BUS_BIT = 2;
  localparam int STAT_VALID_BIT = 3;

  // Shared analog pins start at this bit
  localparam int ANA_SHARED_LSB = 4;

  // Cycles the mode strap must settle after reset release
  localparam logic [1:0] STRAP_SETTLE = 2'h2;

  typedef enum logic [1:0] {
    MODE_MICROPROC = 2'h0,
    MODE_MICROCTRL = 2'h1,
    MODE_EXT_MICROCTRL = 2'h2,
    MODE_PROT_MICROCTRL = 2'h3
  } dgp_mode_t;

  typedef enum logic [1:0] {
    ST_SETTLE = 2'b01,
    ST_RUN = 2'b10
  } dgp_strap_st_t;

endpackage

// File: core/dgp_sync.sv
`timescale 1ns/1ns
`default_nettype none
module dgp_sync import dgp_pkg::*; #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Data
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  if (W < 1) begin : g_bad_w
    $error("dgp_sync width must be at least one");
  end

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // First stage feeds only the second stage
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule
`default_nettype wire

// File: core/dgp_top.sv
// The APB slave port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module dgp_top import dgp_pkg::*; #(
  parameter int BUS_W = 4,
  parameter int ANA_W = 8
) (
  // Clock and resets
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic por_rst_n,

  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [APB_DW-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [APB_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,

  // Operating mode strap
  input wire logic [1:0] oper_mode_strap,

  // System bus strobes from the external bus unit
  input wire logic sysbus_ale,
  input wire logic sysbus_oe_n,
  input wire logic sysbus_wr_n,

  // Bus-control port pads
  input wire logic [BUS_W-1:0] bus_ctrl_pin_i,
  output logic [BUS_W-1:0] bus_ctrl_pin_o,
  output logic [BUS_W-1:0] bus_ctrl_pin_oe,

  // Analog-shared port pads
  input wire logic [ANA_W-1:0] analog_pin_i,
  output logic [ANA_W-1:0] analog_pin_o,
  output logic [ANA_W-1:0] analog_pin_oe,

  // To the capture unit and converter
  output logic capture_input_four,
  output logic [ANA_W-ANA_SHARED_LSB-1:0] analog_sel,
  output logic bus_mode_active
);

  localparam int SH_W = ANA_W - ANA_SHARED_LSB;

  // Register layout is fixed at these widths
  if (BUS_W != 4) begin : g_bad_bus_w
    $error("bus-control port must be four pins wide");
  end
  if (ANA_W != 8) begin : g_bad_ana_w
    $error("analog-shared port must be eight pins wide");
  end
  // Pin roles and fields must sit inside their ports and registers
  if (BUS_CAP_BIT >= BUS_W || BUS_WR_BIT >= BUS_W) begin : g_bad_roles
    $error("bus-control pin roles outside the port");
  end
  if (ANA_SHARED_LSB >= ANA_W) begin : g_bad_shared
    $error("shared analog pins outside the port");
  end
  if (CONV_CFG_LSB + CONV_CFG_W > 8) begin : g_bad_cfg
    $error("port configuration field outside its register");
  end
  if (APB_DW < ANA_W || APB_AW < 3) begin : g_bad_apb
    $error("APB geometry too narrow for the register map");
  end

  // Synchronised pad inputs
  logic [BUS_W-1:0] bus_pin_s;
  logic [ANA_W-1:0] ana_pin_s;
  logic [1:0] strap_s;

  dgp_sync #(.W(BUS_W)) u_sync_bus (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_i(bus_ctrl_pin_i),
    .sync_o(bus_pin_s)
  );

  dgp_sync #(.W(ANA_W)) u_sync_ana (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_i(analog_pin_i),
    .sync_o(ana_pin_s)
  );

  dgp_sync #(.W(2)) u_sync_strap (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_i(oper_mode_strap),
    .sync_o(strap_s)
  );

  // Mode strap capture after reset release
  dgp_strap_st_t strap_st_q;
  logic [1:0] settle_q;
  dgp_mode_t mode_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_st_q <= ST_SETTLE;
    end else begin
      case (strap_st_q)
        ST_SETTLE: begin
          if (settle_q == STRAP_SETTLE) begin
            strap_st_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          strap_st_q <= ST_RUN;
        end
        default: begin
          strap_st_q <= ST_SETTLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      settle_q <= 2'h0;
    end else if (strap_st_q == ST_SETTLE && settle_q != STRAP_SETTLE) begin
      settle_q <= settle_q + 2'h1;
    end
  end

  // Until settled the pins stay plain I/O, so no strobe glitches out
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= MODE_MICROCTRL;
    end else if (strap_st_q == ST_SETTLE && settle_q == STRAP_SETTLE) begin
      mode_q <= dgp_mode_t'(strap_s);
    end
  end

  logic bus_take;
  assign bus_take = (strap_st_q == ST_RUN) &&
                    (mode_q == MODE_MICROPROC || mode_q == MODE_EXT_MICROCTRL);
  assign bus_mode_active = bus_take;

  // APB decode
  logic [IDX_W-1:0] idx;
  logic aligned;
  logic setup_ph;
  logic wr_ok;
  logic hit_ana_dir;
  logic hit_ana_data;
  logic hit_bus_data;
  logic hit_bus_dir;
  logic hit_status;
  logic hit_conv;
  logic hit_any;

  assign idx = paddr[APB_AW-1:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign setup_ph = psel & ~penable;
  assign hit_ana_dir = aligned && idx == IDX_ANA_DIR;
  assign hit_ana_data = aligned && idx == IDX_ANA_DATA;
  assign hit_bus_data = aligned && idx == IDX_BUS_DATA;
  assign hit_bus_dir = aligned && idx == IDX_BUS_DIR;
  assign hit_status = aligned && idx == IDX_STATUS;
  assign hit_conv = aligned && idx == IDX_CONV_CTRL;
  assign hit_any = hit_ana_dir | hit_ana_data | hit_bus_data |
                   hit_bus_dir | hit_status | hit_conv;

  // Zero-wait slave: every access ends in its first access cycle
  assign pready = 1'b1;
  assign wr_ok = psel & penable & pwrite & pstrb[0];

  // Port state
  logic [BUS_W-1:0] bus_latch_q;
  logic [BUS_W-1:0] bus_dir_q;
  logic [ANA_W-1:0] ana_dir_q;
  logic [SH_W-1:0] ana_latch_hi_q;
  logic [ANA_W-SH_W-1:0] ana_latch_lo_q;
  logic [7:0] conv_ctrl_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_latch_q <= BUS_DATA_RST;
    end else if (wr_ok && hit_bus_data) begin
      bus_latch_q <= pwdata[BUS_W-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_dir_q <= BUS_DIR_RST;
    end else if (wr_ok && hit_bus_dir) begin
      bus_dir_q <= pwdata[BUS_W-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ana_dir_q <= ANA_DIR_RST;
    end else if (wr_ok && hit_ana_dir) begin
      ana_dir_q <= pwdata[ANA_W-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ana_latch_hi_q <= ANA_DATA_HI_RST;
    end else if (wr_ok && hit_ana_data) begin
      ana_latch_hi_q <= pwdata[ANA_W-1:ANA_SHARED_LSB];
    end
  end

  // Low nibble survives a warm reset; only power-on clears it
  always_ff @(posedge ref_clk or negedge por_rst_n) begin
    if (!por_rst_n) begin
      ana_latch_lo_q <= ANA_DATA_LO_RST;
    end else if (wr_ok && hit_ana_data) begin
      ana_latch_lo_q <= pwdata[ANA_SHARED_LSB-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_ctrl_q <= CONV_CTRL_RST;
    end else if (wr_ok && hit_conv) begin
      conv_ctrl_q <= pwdata[7:0] & CONV_CTRL_WMASK;
    end
  end

  // Analog selection of the shared pins
  logic [CONV_CFG_W-1:0] port_config_field;
  assign port_config_field = conv_ctrl_q[CONV_CFG_LSB +: CONV_CFG_W];
  assign analog_sel = (port_config_field < CFG_DIGITAL_FROM) ? {SH_W{1'b1}} : '0;

  // Digital read path, analog pins forced to zero
  logic [ANA_W-1:0] ana_read;
  assign ana_read = {ana_pin_s[ANA_W-1:ANA_SHARED_LSB] & ~analog_sel,
                     ana_pin_s[ANA_SHARED_LSB-1:0]};

  logic [7:0] status_val;
  always_comb begin
    status_val = 8'h00;
    status_val[STAT_MODE_LSB +: 2] = mode_q;
    status_val[STAT_BUS_BIT] = bus_take;
    status_val[STAT_VALID_BIT] = (strap_st_q == ST_RUN);
  end

  // Read data captured in the setup cycle, held for the access cycle
  logic [APB_DW-1:0] rdata_d;
  logic [APB_DW-1:0] rdata_q;
  logic slverr_q;

  always_comb begin
    rdata_d = '0;
    case (1'b1)
      hit_ana_dir: rdata_d[ANA_W-1:0] = ana_dir_q;
      hit_ana_data: rdata_d[ANA_W-1:0] = ana_read;
      hit_bus_data: rdata_d[BUS_W-1:0] = bus_pin_s;
      hit_bus_dir: rdata_d[BUS_W-1:0] = bus_dir_q;
      hit_status: rdata_d[7:0] = status_val;
      hit_conv: rdata_d[7:0] = conv_ctrl_q;
      default: rdata_d = '0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else if (setup_ph) begin
      rdata_q <= pwrite ? '0 : rdata_d;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      slverr_q <= 1'b0;
    end else if (setup_ph) begin
      slverr_q <= ~hit_any;
    end
  end

  assign prdata = rdata_q;
  assign pslverr = slverr_q & psel & penable;

  // Bus-control pin functions
  logic [BUS_W-1:0] bus_alt_en;
  logic [BUS_W-1:0] bus_alt_val;

  always_comb begin
    bus_alt_en = bus_take ? BUS_TAKE_MASK : '0;
    bus_alt_val = '0;
    bus_alt_val[BUS_ALE_BIT] = sysbus_ale;
    bus_alt_val[BUS_OE_BIT] = sysbus_oe_n;
    bus_alt_val[BUS_WR_BIT] = sysbus_wr_n;
  end

  dgp_pin_mux #(.W(BUS_W)) u_mux_bus (
    .latch(bus_latch_q),
    .dir(bus_dir_q),
    .alt_en(bus_alt_en),
    .alt_val(bus_alt_val),
    .pin_o(bus_ctrl_pin_o),
    .pin_oe(bus_ctrl_pin_oe)
  );

  // Fourth pin also feeds capture in every mode
  assign capture_input_four = bus_pin_s[BUS_CAP_BIT];

  dgp_pin_mux #(.W(ANA_W)) u_mux_ana (
    .latch({ana_latch_hi_q, ana_latch_lo_q}),
    .dir(ana_dir_q),
    .alt_en({ANA_W{1'b0}}),
    .alt_val({ANA_W{1'b0}}),
    .pin_o(analog_pin_o),
    .pin_oe(analog_pin_oe)
  );

endmodule
`default_nettype wire

// File: dv/dgp_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module dgp_checker import dgp_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [APB_DW-1:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [APB_DW-1:0] prdata,
  input wire logic pslverr,
  // Mode, strobes and pads
  input wire logic [1:0] oper_mode_strap,
  input wire logic sysbus_ale,
  input wire logic sysbus_oe_n,
  input wire logic sysbus_wr_n,
  input wire logic [3:0] bus_ctrl_pin_o,
  input wire logic [3:0] bus_ctrl_pin_oe,
  input wire logic [7:0] analog_pin_oe,
  input wire logic [3:0] analog_sel,
  input wire logic bus_mode_active
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic wr;
  logic [3:0] bdir_q;
  logic [7:0] adir_q;
  logic [3:0] port_cfg_q;
  assign wr = psel && penable && pwrite && pstrb[0];
  // Shadow copies so pads can be tied to what software wrote
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bdir_q <= BUS_DIR_RST;
      adir_q <= ANA_DIR_RST;
      port_cfg_q <= 4'h0;
    end else if (wr) begin
      if (paddr == 8'h4C) bdir_q <= pwdata[3:0];
      if (paddr == 8'h40) adir_q <= pwdata[7:0];
      if (paddr == 8'h54) port_cfg_q <= pwdata[3:0];
    end
  end
  AST_BUS_OE: assert property (!bus_mode_active |->
    bus_ctrl_pin_oe == ~bdir_q) else $error("bus pad enable wrong");
  AST_PIN3: assert property (
    bus_ctrl_pin_oe[3] == ~bdir_q[3]) else $error("pin 3 taken over");
  AST_STROBE: assert property (bus_mode_active |->
    bus_ctrl_pin_o[2:0] == {sysbus_wr_n, sysbus_oe_n, sysbus_ale})
    else $error("strobe pads wrong");
  AST_TAKE: assert property (
    bus_mode_active |-> bus_ctrl_pin_oe[2:0] == 3'h7) else $error("strobe pads not driven");
  AST_MODE: assert property (
    bus_mode_active |-> !oper_mode_strap[0]) else $error("takeover in chip-only mode");
  AST_ANA_OE: assert property (
    analog_pin_oe == ~adir_q) else $error("analog pad enable wrong");
  AST_RST_DIR: assert property (
    $rose(rst_n) |-> (analog_pin_oe == 8'h00) [*2]) else $error("analog pads drive after reset");
  AST_SEL: assert property (
    analog_sel == {4{port_cfg_q < 4'h8}}) else $error("analog select wrong");
  AST_RD: assert property (psel && penable && !pwrite && paddr == 8'h44 &&
    $past(analog_sel) == 4'hF |-> prdata[7:4] == 4'h0) else $error("analog bits read set");
  cover property (bus_mode_active);
  cover property (pslverr);
  cover property (psel && penable && paddr == 8'h44);
endmodule
bind dgp_top dgp_checker chk_u (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pstrb, .prdata, .pslverr, .oper_mode_strap, .sysbus_ale, .sysbus_oe_n,
  .sysbus_wr_n, .bus_ctrl_pin_o, .bus_ctrl_pin_oe, .analog_pin_oe, .analog_sel,
  .bus_mode_active);
`default_nettype wire

// File: dv/dgp_pads.sv
`timescale 1ns/1ns
`default_nettype none
module dgp_pads (
  // Pad drive from the port
  input wire logic [3:0] bus_o,
  input wire logic [3:0] bus_oe,
  input wire logic [7:0] ana_o,
  input wire logic [7:0] ana_oe,
  // Level the outside world puts on released pads
  input wire logic [3:0] bus_ext,
  input wire logic [7:0] ana_ext,
  // Resolved pad levels
  output logic [3:0] bus_i,
  output logic [7:0] ana_i
);
  // A driven pad wins; the outside device backs off there
  assign bus_i = (bus_oe & bus_o) | (~bus_oe & bus_ext);
  assign ana_i = (ana_oe & ana_o) | (~ana_oe & ana_ext);
endmodule
`default_nettype wire

// File: dv/dgp_top_bench.sv
`timescale 1ns/1ns
`default_nettype none
module dgp_top_bench import dgp_pkg::*;;
  logic ref_clk, rst_n, por_rst_n, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb, bus_i, bus_o, bus_oe, bus_ext, sel;
  logic [7:0] ana_i, ana_o, ana_oe, ana_ext;
  logic [1:0] strap;
  logic ale, oe_n, wr_n, cap, bma;
  int err_count, checks_done;
  dgp_top dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .por_rst_n(por_rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .oper_mode_strap(strap),
    .sysbus_ale(ale), .sysbus_oe_n(oe_n), .sysbus_wr_n(wr_n), .bus_ctrl_pin_i(bus_i),
    .bus_ctrl_pin_o(bus_o), .bus_ctrl_pin_oe(bus_oe), .analog_pin_i(ana_i),
    .analog_pin_o(ana_o), .analog_pin_oe(ana_oe), .capture_input_four(cap),
    .analog_sel(sel), .bus_mode_active(bma));
  dgp_pads pads_u (.bus_o(bus_o), .bus_oe(bus_oe), .ana_o(ana_o), .ana_oe(ana_oe),
    .bus_ext(bus_ext), .ana_ext(ana_ext), .bus_i(bus_i), .ana_i(ana_i));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task test_done;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t seen %h expected %h", $time, got, exp);
    end
  endtask
  // Flat map, so no bank choice is needed first
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge ref_clk);
      if (pready === 1'b1) break;
    end
    if (n == 16) begin
      err_count++;
      test_done;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task rst(input logic [1:0] m, input logic por);
    rst_n <= 1'b0;
    por_rst_n <= !por;
    strap <= m;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    por_rst_n <= 1'b1;
    repeat (10) @(posedge ref_clk);
  endtask
  initial begin
    err_count = 0;
    checks_done = 0;
    {rst_n, por_rst_n, psel, penable, pwrite} = 5'h0;
    {paddr, pwdata, pstrb, strap} = '0;
    pstrb = 4'hF;
    {ale, oe_n, wr_n} = 3'h5;
    bus_ext = 4'h9;
    ana_ext = 8'hA5;
    rst(2'h1, 1'b1);
    rdc(8'h40, 32'hFF);
    rdc(8'h54, 32'h0);
    chk({28'h0, sel}, 32'hF);
    rdc(8'h44, 32'h05);
    apb(1'b1, 8'h54, 32'h8);
    rdc(8'h44, 32'hA5);
    chk({28'h0, sel}, 32'h0);
    // A write without the low byte strobe must be dropped
    pstrb <= 4'hE;
    apb(1'b1, 8'h54, 32'h0);
    pstrb <= 4'hF;
    rdc(8'h54, 32'h8);
    apb(1'b1, 8'h54, 32'hFF);
    rdc(8'h54, 32'hEF);
    rdc(8'h48, 32'h9);
    apb(1'b1, 8'h48, 32'h5);
    rdc(8'h48, 32'h9);
    apb(1'b1, 8'h4C, 32'h0);
    repeat (2) @(posedge ref_clk);
    chk({28'h0, bus_oe}, 32'hF);
    chk({28'h0, bus_o}, 32'h5);
    rdc(8'h48, 32'h5);
    chk({31'h0, er}, 32'h0);
    apb(1'b0, 8'h7C, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b0, 8'h41, 32'h0);
    chk({31'h0, er}, 32'h1);
    // Low nibble survives a warm reset only
    apb(1'b1, 8'h44, 32'h3C);
    rst(2'h1, 1'b0);
    rdc(8'h40, 32'hFF);
    apb(1'b1, 8'h40, 32'h0);
    chk({24'h0, ana_o}, 32'h0C);
    rst(2'h1, 1'b1);
    apb(1'b1, 8'h40, 32'h0);
    chk({24'h0, ana_o}, 32'h0);
    for (int m = 0; m < 4; m++) begin
      rst(m[1:0], 1'b1);
      chk({31'h0, bma}, {31'h0, !m[0]});
      chk({28'h0, bus_oe}, m[0] ? 32'h0 : 32'h7);
      chk({29'h0, bus_o[2:0]}, m[0] ? 32'h0 : 32'h5);
      chk({31'h0, cap}, 32'h1);
      rdc(8'h50, {28'h0, 1'b1, !m[0], m[1:0]});
      // Uneven strobe pattern catches swapped pins
      {ale, oe_n, wr_n} <= 3'h4;
      @(posedge ref_clk);
      chk({29'h0, bus_o[2:0]}, m[0] ? 32'h0 : 32'h1);
      {ale, oe_n, wr_n} <= 3'h5;
    end
    test_done;
  end
endmodule
`default_nettype wire
